/* rolling_shutter_frame_timing.sv */
// Frame capture and readout timing for a rolling-shutter array.
// Assumes settings arrive as static levels on the clock domain; the
// trigger comes from a pin and is synchronised here.
//
// Overview of operation
// - Mode bit 6 picks continuous or single
// - Reset value selects continuous capture
// - Row integrations staggered one row apart
// - Continuous: next frame starts without trigger
// - Default format: only pixel words output
// - Format bit 5 inserts in-band markers in continuous mode only
// - Marker patterns for first, later, end
// - Single mode idles after frame done
// - Read only pixels inside window
// - Subsample 1, 1/2, 1/4, 1/8 each way
// - Low bits 0010101 select mosaic skip-one
// - Continuous frame is (rows+1) row times, or (rows+2) if the end marker ends on row_end
// - Row time is width+shs+shr+19 clocks
// - Integration is count times row time
// - Continuous integration below frame period
// - Single frame adds (rows+1) readout rows
// - Single integration not capped by frame
`timescale 1ns/10ps
`include "frame_timing_cfg.svh"

module rolling_shutter_frame_timing (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] capture_ctrl,
	input wire logic [7:0] stream_ctrl,
	input wire logic [7:0] subsample_ctrl,
	input wire logic frame_trigger,
	input wire logic [10:0] win_row,
	input wire logic [10:0] win_col,
	input wire logic [10:0] win_depth,
	input wire logic [10:0] win_width,
	input wire logic [10:0] vrow_depth,
	input wire logic [10:0] vcol_width,
	input wire logic [7:0] shs_time,
	input wire logic [7:0] shr_time,
	input wire logic [15:0] integ_count,
	input wire logic [9:0] pixel_in,
	output logic [9:0] pixel_out,
	output logic pixel_valid,
	output logic [10:0] read_row,
	output logic [10:0] read_col,
	output logic reset_row_strobe,
	output logic [10:0] reset_row,
	output logic frame_busy
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Step for a two-bit rate code; mosaic space doubles the unit.
	function automatic logic [4:0] step_of(input logic [1:0] code,
			input logic color);
		logic [4:0] s;
		s = 5'h01 << code;
		step_of = color ? 5'((s << 1)) : s;
	endfunction

	// Pixel lies on the kept lattice of a subsampled axis.
	function automatic logic keep(input logic [10:0] offs,
			input logic [1:0] code, input logic color);
		logic [4:0] st;
		logic [10:0] unit;
		st = step_of(code, color);
		unit = color ? (offs >> 1) : offs;
		keep = (5'(unit & 11'(st - 5'h01)) == 5'h00) || (code == 2'h0);
		if (color && code != 2'h0)
			keep = ((offs >> 1) & ((11'h001 << code) - 11'h001)) == 11'h000;
	endfunction

	// ==========================================================
	// Trigger synchroniser
	// ==========================================================
	logic trig_s1_r;
	logic trig_s2_r;
	logic trig_d_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_d_r <= 1'b0;
		end else begin
			trig_s1_r <= frame_trigger;
			trig_s2_r <= trig_s1_r;
			trig_d_r <= trig_s2_r;
		end
	end
	wire trig_rise = trig_s2_r & ~trig_d_r;

	// ==========================================================
	// Settings decode
	// ==========================================================
	// Mode bit value 0 selects continuous, so reset settings mean continuous
	wire single_capture_mode = capture_ctrl[`MODE_BIT];
	wire continuous_capture_mode = ~single_capture_mode;
	wire encode_on = stream_ctrl[`FMT_BIT] & continuous_capture_mode;
	wire color_sub = subsample_ctrl[`SUB_COLOR_BIT];
	wire [1:0] row_code = subsample_ctrl[1:0];
	wire [1:0] col_code = subsample_ctrl[3:2];
	// Row period in clocks
	wire [15:0] row_clocks = 16'(vcol_width) + 16'(shs_time) +
		16'(shr_time) + `ROW_OVERHEAD;
	// Continuous caps integration below one frame of rows
	wire [15:0] integ_rows = (continuous_capture_mode &&
		integ_count > 16'(vrow_depth)) ? 16'(vrow_depth) :
		integ_count;

	// ==========================================================
	// Sequencer
	// ==========================================================
	// Only the first continuous frame after reset runs its lead-in
	// integration rows on their own. Later frames overlap: while one
	// frame is read out, the rows of the next are integrating. The
	// readout therefore wraps straight from the last virtual row to
	// the first, so the frame period is (rows + 1) row
	// times whatever the integration count, or (rows + 2) when the end marker ends on row_end.
	// The end marker is sent inside the last row time, after its
	// pixels; sent from clk_cnt_r of row_clocks - 5 it ends on row_end, which st_eof ignores, so the frame stretches one row.
	// Limitation: a last row cut short by a small row period, or
	// one that leaves no room after its pixels, carries no end
	// marker.
	// Single mode keeps the plain sequence: lead-in rows, readout
	// rows, then idle until the next trigger.
	frame_timing_pkg::state_t state_r;
	logic eof_sent_r;
	logic [15:0] clk_cnt_r;
	logic [15:0] row_idx_r;
	logic [10:0] col_r;
	logic [2:0] mark_r;
	logic first_row_r;
	wire row_end = (clk_cnt_r == row_clocks - 16'h0001);
	// Readout row index counts virtual rows after integration lead-in
	wire [15:0] rd_row = row_idx_r - integ_rows;
	wire rd_active = (row_idx_r >= integ_rows);
	wire [10:0] rd_offs = 11'(rd_row);
	wire row_in_win = rd_active && rd_offs <= win_depth &&
		keep(rd_offs, row_code, color_sub);
	wire last_rd = rd_active && (rd_offs == vrow_depth);
	wire [15:0] last_idx = integ_rows + 16'(vrow_depth);
	// Last readout row of the frame is in progress (whole row time)
	wire frame_last = (row_idx_r == last_idx);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= frame_timing_pkg::st_idle;
			clk_cnt_r <= 16'h0000;
			row_idx_r <= 16'h0000;
			col_r <= 11'h000;
			mark_r <= 3'h0;
			first_row_r <= 1'b1;
			eof_sent_r <= 1'b0;
		end else begin
			clk_cnt_r <= row_end ? 16'h0000 : clk_cnt_r + 16'h0001;
			case (state_r)
			frame_timing_pkg::st_idle: begin
				clk_cnt_r <= 16'h0000;
				row_idx_r <= 16'h0000;
				first_row_r <= 1'b1;
				eof_sent_r <= 1'b0;
				// Continuous restarts alone; single waits for trigger
				if (continuous_capture_mode || trig_rise)
					state_r <= frame_timing_pkg::st_integ;
			end
			frame_timing_pkg::st_integ: begin
				// Rows start integrating one row time apart
				if (row_end) begin
					row_idx_r <= row_idx_r + 16'h0001;
					if (row_idx_r + 16'h0001 >= integ_rows)
						state_r <= frame_timing_pkg::st_rowgap;
				end
			end
			frame_timing_pkg::st_rowgap: begin
				if (clk_cnt_r == 16'h0000 && row_in_win) begin
					mark_r <= 3'h0;
					col_r <= 11'h000;
					state_r <= encode_on ? frame_timing_pkg::st_mark :
						frame_timing_pkg::st_pixels;
				end else if (row_end) begin
					row_idx_r <= row_idx_r + 16'h0001;
					if (frame_last) begin
						// Readout wraps into the next frame
						row_idx_r <= integ_rows;
						first_row_r <= 1'b1;
						eof_sent_r <= 1'b0;
						if (single_capture_mode)
							state_r <= frame_timing_pkg::st_idle;
					end
				end else if (encode_on && last_rd && !eof_sent_r &&
						clk_cnt_r < row_clocks - 16'(`EOF_WORDS)) begin
					// End marker fits inside the last row time
					mark_r <= 3'h0;
					eof_sent_r <= 1'b1;
					state_r <= frame_timing_pkg::st_eof;
				end
			end
			frame_timing_pkg::st_mark: begin
				mark_r <= mark_r + 3'h1;
				if (mark_r == (first_row_r ? `SOF_WORDS :
						`ROWMARK_WORDS) - 3'h1)
					state_r <= frame_timing_pkg::st_pixels;
			end
			frame_timing_pkg::st_pixels: begin
				col_r <= col_r + 11'h001;
				if (col_r == win_width) begin
					first_row_r <= 1'b0;
					state_r <= frame_timing_pkg::st_rowgap;
				end
				if (row_end) begin
					// Row period too short for window: row is cut here
					row_idx_r <= row_idx_r + 16'h0001;
					first_row_r <= 1'b0;
					state_r <= frame_timing_pkg::st_rowgap;
					if (frame_last) begin
						row_idx_r <= integ_rows;
						first_row_r <= 1'b1;
						eof_sent_r <= 1'b0;
						if (single_capture_mode)
							state_r <= frame_timing_pkg::st_idle;
					end
				end
			end
			frame_timing_pkg::st_eof: begin
				mark_r <= mark_r + 3'h1;
				if (mark_r == `EOF_WORDS - 3'h1)
					state_r <= frame_timing_pkg::st_rowgap;
			end
			default: state_r <= frame_timing_pkg::st_idle;
			endcase
		end
	end

	// ==========================================================
	// Stream output
	// ==========================================================
	// Markers: ones-ones-ones first row, ones-ones-zero-zero later,
	// four zero words at end of frame.
	logic [9:0] word_nxt;
	logic valid_nxt;
	wire col_keep = keep(col_r, col_code, color_sub);
	always_comb begin
		word_nxt = `MARK_ZERO;
		valid_nxt = 1'b0;
		case (state_r)
		frame_timing_pkg::st_mark: begin
			valid_nxt = 1'b1;
			word_nxt = (first_row_r || mark_r < 3'h2) ? `MARK_ONES :
				`MARK_ZERO;
		end
		frame_timing_pkg::st_eof: begin
			valid_nxt = 1'b1;
			word_nxt = `MARK_ZERO;
		end
		frame_timing_pkg::st_pixels: begin
			valid_nxt = col_keep;
			word_nxt = col_keep ? pixel_in : `MARK_ZERO;
		end
		default: begin
			word_nxt = `MARK_ZERO;
			valid_nxt = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pixel_out <= 10'h000;
			pixel_valid <= 1'b0;
			read_row <= 11'h000;
			read_col <= 11'h000;
		end else begin
			pixel_out <= word_nxt;
			pixel_valid <= valid_nxt;
			read_row <= win_row + rd_offs;
			// Address leads the word by one cycle: the array answers
			// on the next clock, when that column is being sent.
			read_col <= win_col + ((state_r == frame_timing_pkg::st_pixels)
				? col_r + 11'h001 : 11'h000);
		end
	end

	// Integration start pulse for the row entering exposure
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reset_row_strobe <= 1'b0;
			reset_row <= 11'h000;
			frame_busy <= 1'b0;
		end else begin
			// One pulse per row time while a frame runs
			reset_row_strobe <= (clk_cnt_r == 16'h0000) &&
				state_r != frame_timing_pkg::st_idle;
			reset_row <= win_row + 11'(row_idx_r);
			frame_busy <= state_r != frame_timing_pkg::st_idle;
		end
	end

endmodule

/* frame_timing_cfg.svh */
// Timing constants, field positions and marker words for the frame timing block.
// Assumes inclusion by bare name from the design files.
`ifndef FRAME_TIMING_CFG_SVH
`define FRAME_TIMING_CFG_SVH
`define MODE_BIT 6
`define FMT_BIT 5
`define ROW_OVERHEAD 16'h0013
`define MARK_ONES 10'h3ff
`define MARK_ZERO 10'h000
`define SOF_WORDS 3'h3
`define ROWMARK_WORDS 3'h4
`define EOF_WORDS 3'h4
`define SUB_COLOR_BIT 4
`endif

/* frame_timing_pkg.sv */
// Types for the frame timing block.
// Assumes frame_timing_cfg.svh is compiled alongside.
package frame_timing_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_integ,
		st_mark,
		st_pixels,
		st_rowgap,
		st_eof
	} state_t;
endpackage

/* frame_timing_properties.sv */
// Port checker for the frame timing block.
// Assumes a bind onto the block; one clock, async reset.
`timescale 1ns/10ps
module frame_timing_properties (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] capture_ctrl,
	input wire logic frame_trigger,
	input wire logic [10:0] vcol_width,
	input wire logic [7:0] shs_time,
	input wire logic [7:0] shr_time,
	input wire logic pixel_valid,
	input wire logic reset_row_strobe,
	input wire logic frame_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// =====================================
	// Row spacing counter
	logic [12:0] gap_r;
	wire [12:0] rc = vcol_width + shs_time + shr_time + 13'h0013;
	// Saturates so idle gaps between single frames cannot wrap
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			gap_r <= 13'h0000;
		else if (reset_row_strobe)
			gap_r <= 13'h0001;
		else if (gap_r != 13'h0000 && gap_r != 13'h1fff)
			gap_r <= gap_r + 13'h0001;
	end
	// =====================================
	// Properties
	sequence s_trig;
		capture_ctrl[6] && !frame_busy && $rose(frame_trigger);
	endsequence
	sequence s_quiet;
		(capture_ctrl[6] && !frame_trigger && !frame_busy) [*6];
	endsequence
	a_strobe_one_pulse: assert property (reset_row_strobe |=> !reset_row_strobe) else $error("row strobe longer than one cycle");
	a_row_gap_min: assert property (reset_row_strobe && gap_r != 13'h0000 |-> gap_r >= rc) else $error("row period too short");
	a_single_waits: assert property (s_quiet |=> !frame_busy) else $error("single frame began untriggered");
	a_trigger_starts: assert property (s_trig |-> ##[2:6] frame_busy) else $error("trigger did not start frame");
	a_cont_restart: assert property (!capture_ctrl[6] && frame_busy |=> frame_busy) else $error("continuous framing stopped");
	a_idle_quiet: assert property (!frame_busy && !$past(frame_busy) |-> !pixel_valid) else $error("words while idle");
	a_reset_quiet: assert property ($past(!resetn) |-> !pixel_valid && !frame_busy) else $error("outputs active after reset");
	a_single_stays_idle: assert property (capture_ctrl[6] && !frame_trigger && $fell(frame_busy) ##1 !frame_trigger [*3] |-> !frame_busy) else $error("single frame rerun");
endmodule
bind rolling_shutter_frame_timing frame_timing_properties chk (.*);

/* pixel_array_model.sv */
// Pixel array stand-in returning a word coded from the address.
// Assumes read_row and read_col come straight from the block.
`timescale 1ns/10ps
module pixel_array_model (
	input wire logic [10:0] read_row,
	input wire logic [10:0] read_col,
	output logic [9:0] pixel_in
);
	// Top bits 01 keep pixels clear of the marker words
	assign pixel_in = {2'b01, read_row[3:0], read_col[3:0]};
endmodule

/* tb.sv */
// Self-checking bench for the frame timing block.
// Assumes the array model and the bound checker.
`timescale 1ns/10ps
module tb;
	logic clock = 1'b0, resetn = 1'b0, frame_trigger = 1'b0;
	logic [7:0] capture_ctrl = 8'h00, stream_ctrl = 8'h00, subsample_ctrl = 8'h00;
	logic [10:0] win_row = 11'h000, win_col = 11'h000;
	logic [10:0] win_depth = 11'h003, win_width = 11'h003;
	logic [10:0] vrow_depth = 11'h003, vcol_width = 11'h008;
	logic [7:0] shs_time = 8'h01, shr_time = 8'h01;
	logic [15:0] integ_count = 16'h0005;
	logic [9:0] pixel_in, pixel_out;
	logic pixel_valid, reset_row_strobe, frame_busy;
	logic [10:0] read_row, read_col, reset_row;
	int errors = 0, check_count = 0, k;
	logic [9:0] got[$], exp[$];
	// Row is 8+1+1+19 clocks; virtual frame is 4 rows
	localparam int RC = 29;
	localparam int FR = 116;
	rolling_shutter_frame_timing uut (.*);
	pixel_array_model array (.*);
	initial forever #50 clock = ~clock;
	// =====================================
	// Shared tasks
	task check(input string what, input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task restart(input logic [7:0] cap, input logic [7:0] fmt, input logic [7:0] sub);
		@(negedge clock);
		resetn = 1'b0;
		capture_ctrl = cap;
		stream_ctrl = fmt;
		subsample_ctrl = sub;
		repeat (10) @(negedge clock);
		resetn = 1'b1;
	endtask
	function logic [9:0] px(int r, int c);
		return {2'b01, r[3:0], c[3:0]};
	endfunction
	task wait_valid;
		k = 0;
		while (pixel_valid !== 1'b1 && k < 2000) begin
			@(negedge clock);
			k++;
		end
	endtask
	// Ends before the next frame's first word can appear
	task grab;
		got = {};
		wait_valid();
		repeat (FR - 2) begin
			if (pixel_valid === 1'b1)
				got.push_back(pixel_out);
			@(negedge clock);
		end
	endtask
	task compare(input string what);
		check({what, " count"}, got.size(), exp.size());
		foreach (exp[i])
			if (i < got.size())
				check(what, got[i], exp[i]);
	endtask
	// =====================================
	// Scenarios
	task t_default;
		win_row = 11'h002;
		win_col = 11'h001;
		win_depth = 11'h001;
		restart(8'h00, 8'h00, 8'h00);
		grab();
		exp = {};
		for (int r = 2; r < 4; r++)
			for (int c = 1; c < 5; c++)
				exp.push_back(px(r, c));
		compare("plain stream");
		wait_valid();
		check("frame period", k, 2);
		@(posedge reset_row_strobe);
		@(negedge clock);
		@(negedge clock);
		k = 1;
		while (reset_row_strobe !== 1'b1 && k < 200) begin
			@(negedge clock);
			k++;
		end
		check("row period", k, RC);
		$display("done default stream");
	endtask
	task t_markers;
		win_row = 11'h000;
		win_col = 11'h000;
		win_depth = 11'h003;
		restart(8'h00, 8'h20, 8'h00);
		grab();
		exp = {10'h3ff, 10'h3ff, 10'h3ff};
		for (int r = 0; r < 4; r++) begin
			if (r > 0)
				exp = {exp, 10'h3ff, 10'h3ff, 10'h000, 10'h000};
			for (int c = 0; c < 4; c++)
				exp.push_back(px(r, c));
		end
		exp = {exp, 10'h000, 10'h000, 10'h000, 10'h000};
		compare("marked stream");
		$display("done markers");
	endtask
	task t_subsample;
		for (int q = 0; q < 5; q++) begin
			restart(8'h00, 8'h00, q == 4 ? 8'h15 : 8'({q[1:0], q[1:0]}));
			grab();
			exp = {};
			for (int r = 0; r < 4; r++)
				for (int c = 0; c < 4; c++)
					if (q == 4 ? (r < 2 && c < 2) : (r % (1 << q) == 0 && c % (1 << q) == 0))
						exp.push_back(px(r, c));
			compare("subsampled");
		end
		$display("done subsample");
	endtask
	task t_single;
		restart(8'h40, 8'h00, 8'h00);
		repeat (300) @(negedge clock);
		check("untriggered busy", frame_busy, 1'b0);
		frame_trigger = 1'b1;
		repeat (4) @(negedge clock);
		frame_trigger = 1'b0;
		k = 0;
		while (frame_busy !== 1'b1 && k < 20) begin
			@(negedge clock);
			k++;
		end
		k = 0;
		while (frame_busy === 1'b1 && k < 2000) begin
			@(negedge clock);
			k++;
		end
		check("single frame", k, 9 * RC);
		repeat (100) @(negedge clock);
		check("idle after frame", frame_busy, 1'b0);
		$display("done single frame");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#2000000;
		errors++;
		end_sim();
	end
	initial begin
		t_default();
		t_markers();
		t_subsample();
		t_single();
		end_sim();
	end
endmodule
